// ==== common/ihw_pkg.sv ====
// constants, register map and carrier types of the system-control block
package ihw_pkg;
   // clock and times as printed
   localparam int CLK_PERIOD_NS = 20;
   localparam int CLK_HZ = 50_000_000;
   localparam int AUDIO_RATE_HZ = 32768;
   localparam int RESTART_DELAY_NS = 352_000;
   localparam int WDT_TIMEOUT_NS = 128_000_000;
   // least time rounds up, longest rounds down
   localparam int RESTART_DELAY_CYC = (RESTART_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDT_TIMEOUT_CYC = WDT_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int AUDIO_PERIOD_CYC = CLK_HZ / AUDIO_RATE_HZ;

   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_STATUS = 5'h00;
   localparam logic [4:0] IDX_AUD_LOWEST = 5'h08;
   localparam logic [4:0] IDX_AUD_CTRL = 5'h09;
   localparam logic [4:0] IDX_AUD_LOW = 5'h0a;
   localparam logic [4:0] IDX_AUD_HIGH = 5'h0b;
   localparam logic [4:0] IDX_ROM_HIGH = 5'h1d;

   // field positions
   localparam int STATUS_ZERO_BIT = 0;
   localparam int STATUS_CARRY_BIT = 1;
   localparam int STATUS_FLAG_BIT = 2;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_GIE_BIT = 1;
   localparam int SIGN_BIT = 3;

   // reset values
   localparam logic RST_GIE = 1'b0;
   localparam logic RST_AUD_EN = 1'b0;
   localparam logic RST_FLAG = 1'b0;
   localparam logic [3:0] RST_NIBBLE = 4'h0;

   // program counter vectors
   localparam logic [11:0] VEC_RESET = 12'h000;
   localparam logic [11:0] VEC_WAKE = 12'h004;
   localparam logic [11:0] VEC_INT = 12'h008;

   typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAKE, ST_RESET} ihw_state_t;

   // processor context saved on interrupt entry
   typedef struct packed {
      logic [11:0] pc;
      logic [3:0] page;
      logic [3:0] memory_address_high;
      logic [1:0] cz;
   } ihw_ctx_t;

   typedef struct packed {
      logic [11:0] pc;
      logic [3:0] page;
      logic [3:0] memory_address_high;
   } ihw_core_t;
endpackage

// ==== src/ihw_sysctl.sv ====
// interrupt, halt/wakeup, watchdog and pulse-width audio control
// Functional notes
// - one interrupt entry: program counter loaded with 0x008 on every take
// - audio-cycle request recurs at 32768 Hz in normal operation
// - enable set and audio flag one: interrupt taken on the next clock
// - in one clock save next pc, page, address-high, carry/zero; load vector
// - taking the interrupt clears the global interrupt enable
// - hardware never clears the audio flag on take; software clears it
// - return-from-interrupt restores saved context and sets the enable
// - no nesting; a request is taken only while the enable is set
// - halt stops program counter and system clock until wakeup or reset
// - halt loads pc 0x004; after wakeup runs on after 352 us delay
// - rising edge on an enabled wake pin while halted wakes the device
// - reset in halt wins: pc 0x000, resume after 352 us delay
// - working memory untouched during halt
// - watchdog cleared on wakeup, after reset and on software clear
// - watchdog times out at 0.128 s and resets the whole chip
// - any write to the rom-data high nibble clears the watchdog
// - halt instruction clears the watchdog
// - 8, 10 and 12 bit audio; top data bit is sign, one negative
// - control bit 0 enables audio output, bit 1 is global enable
// - low nibble gives bits 3..0, 5..2 or 7..4 per mode
// - lowest nibble gives bits 1..0 from 3..2, or bits 3..0 in 12 bit
// - request raised at end of each output cycle; new sample loaded then
// - high nibble gives bits 7..4, 9..6 or 11..8; its bit 3 is sign
// - audio output disabled: both audio pins driven low
// - halt clears audio enable and floats both audio pins
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ihw_sysctl #(
   parameter int RESTART_DELAY_CYC = ihw_pkg::RESTART_DELAY_CYC,
   parameter int WDT_TIMEOUT_CYC = ihw_pkg::WDT_TIMEOUT_CYC,
   parameter int AUDIO_PERIOD_CYC = ihw_pkg::AUDIO_PERIOD_CYC
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire ihw_pkg::ihw_core_t core_ctx,
   input wire logic core_cz_we,
   input wire logic [1:0] core_cz,
   input wire logic instr_return_from_interrupt_instr,
   input wire logic instr_halt,
   input wire logic [1:0] wake_pin,
   input wire logic [1:0] wake_enable_option,
   input wire logic wdt_enable_option,
   input wire logic ten_bit_select_option,
   input wire logic twelve_bit_select_option,
   output logic pc_load,
   output logic [11:0] pc_load_addr,
   output logic ctx_restore,
   output ihw_pkg::ihw_ctx_t restore_ctx,
   output logic [1:0] carry_zero,
   output logic core_run,
   output logic halted,
   output logic wdt_chip_reset,
   output logic audio_out_positive,
   output logic audio_out_negative,
   output logic audio_out_oe
);
   localparam int DLY_W = $clog2(RESTART_DELAY_CYC + 1);
   localparam int WDT_W = $clog2(WDT_TIMEOUT_CYC + 1);
   localparam int AUD_W = 11;

   // apb slave, one wait state
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   wire logic access = psel & penable;
   wire logic [4:0] idx = paddr[6:2];
   wire logic aligned = (paddr[1:0] == 2'h0) & ~paddr[7];
   wire logic hit_status = aligned & (idx == ihw_pkg::IDX_STATUS);
   wire logic hit_lowest = aligned & (idx == ihw_pkg::IDX_AUD_LOWEST);
   wire logic hit_ctrl = aligned & (idx == ihw_pkg::IDX_AUD_CTRL);
   wire logic hit_low = aligned & (idx == ihw_pkg::IDX_AUD_LOW);
   wire logic hit_high = aligned & (idx == ihw_pkg::IDX_AUD_HIGH);
   wire logic hit_rom = aligned & (idx == ihw_pkg::IDX_ROM_HIGH);
   wire logic hit_any = hit_status | hit_lowest | hit_ctrl | hit_low | hit_high | hit_rom;
   wire logic wr_fire = access & pready_q & pwrite & hit_any;
   wire logic rd_take = access & ~pready_q & ~pwrite;

   // state
   ihw_pkg::ihw_state_t st_q, st_d;
   logic gie_q, aud_en_q, flag_q, insvc_q;
   logic [1:0] cz_q;
   ihw_pkg::ihw_ctx_t saved_q;
   logic [3:0] lowest_q, low_q, high_q;
   logic [DLY_W-1:0] dly_q;
   logic [WDT_W-1:0] wdt_q;
   logic [AUD_W-1:0] cyc_q;
   logic act_sign_q;
   logic [AUD_W-1:0] act_mag_q;
   logic [1:0] wk_s1_q, wk_s2_q, wk_s3_q;
   logic pc_load_q, ctx_restore_q, core_run_q, halted_q, wdt_rst_q;
   logic [11:0] pc_addr_q;
   ihw_pkg::ihw_ctx_t restore_ctx_q;
   logic out_p_q, out_n_q, out_oe_q;

   wire logic [3:0] wnib = pwdata[3:0];
   wire logic run = (st_q == ihw_pkg::ST_RUN);
   wire logic halt_go = run & instr_halt;
   wire logic take = run & gie_q & flag_q & ~insvc_q & ~instr_halt;
   wire logic return_from_interrupt_instr_go = run & instr_return_from_interrupt_instr & insvc_q & ~instr_halt;
   // first sync stage read only by the second
   wire logic [1:0] wake_rise = wk_s2_q & ~wk_s3_q & wake_enable_option;
   wire logic wake_go = (st_q == ihw_pkg::ST_HALT) & (|wake_rise);
   wire logic dly_done = (dly_q == DLY_W'(RESTART_DELAY_CYC - 1));
   wire logic wdt_run = run & wdt_enable_option;
   wire logic wdt_ovf = wdt_run & (wdt_q == WDT_W'(WDT_TIMEOUT_CYC - 1));
   wire logic rom_wr = wr_fire & hit_rom;
   wire logic wdt_clr = rom_wr | halt_go | wake_go;
   wire logic cyc_end = run & (cyc_q == AUD_W'(AUDIO_PERIOD_CYC - 1));
   wire logic flag_clr = wr_fire & hit_status & ~wnib[ihw_pkg::STATUS_FLAG_BIT];

   // sample assembly per resolution
   wire logic [AUD_W-1:0] mag8 = {4'h0, high_q[2:0], low_q};
   wire logic [AUD_W-1:0] mag10 = {2'h0, high_q[2:0], low_q, lowest_q[3:2]};
   wire logic [AUD_W-1:0] mag12 = {high_q[2:0], low_q, lowest_q};
   wire logic [AUD_W-1:0] mag_sel = twelve_bit_select_option ? mag12 :
                                    ten_bit_select_option ? mag10 : mag8;
   wire logic pulse_on = cyc_q < act_mag_q;
   wire logic [3:0] status_rd = {1'b0, flag_q, cz_q};
   wire logic [3:0] ctrl_rd = {2'b00, gie_q, aud_en_q};
   wire logic [3:0] rd_nib = hit_status ? status_rd : hit_ctrl ? ctrl_rd : 4'h0;

   always_comb begin
      st_d = st_q;
      case (st_q)
         ihw_pkg::ST_RUN: begin
            if (wdt_ovf) begin
               st_d = ihw_pkg::ST_RESET;
            end else if (halt_go) begin
               st_d = ihw_pkg::ST_HALT;
            end
         end
         ihw_pkg::ST_HALT: begin
            if (wake_go) begin
               st_d = ihw_pkg::ST_WAKE;
            end
         end
         ihw_pkg::ST_WAKE, ihw_pkg::ST_RESET: begin
            if (dly_done) begin
               st_d = ihw_pkg::ST_RUN;
            end
         end
         default: st_d = ihw_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= access & ~pready_q;
         pslverr_q <= access & ~pready_q & ~hit_any;
         if (rd_take) begin
            prdata_q <= {28'h000_0000, rd_nib};
         end
      end
   end

   // reset lands in the restart delay with pc at the reset vector
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ihw_pkg::ST_RESET;
         dly_q <= '0;
      end else begin
         st_q <= st_d;
         dly_q <= (st_d != st_q || dly_done) ? '0 : dly_q + DLY_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wdt_q <= '0;
         wdt_rst_q <= 1'b0;
      end else begin
         wdt_rst_q <= wdt_ovf;
         if (wdt_clr | wdt_ovf | ~wdt_run) begin
            wdt_q <= '0;
         end else begin
            wdt_q <= wdt_q + WDT_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wk_s1_q <= 2'b00;
         wk_s2_q <= 2'b00;
         wk_s3_q <= 2'b00;
      end else begin
         wk_s1_q <= wake_pin;
         wk_s2_q <= wk_s1_q;
         wk_s3_q <= wk_s2_q;
      end
   end

   // interrupt control; set of the flag wins over a software clear
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         gie_q <= ihw_pkg::RST_GIE;
         flag_q <= ihw_pkg::RST_FLAG;
         insvc_q <= 1'b0;
         saved_q <= '0;
      end else if (wdt_ovf) begin
         gie_q <= ihw_pkg::RST_GIE;
         flag_q <= ihw_pkg::RST_FLAG;
         insvc_q <= 1'b0;
      end else begin
         if (cyc_end) begin
            flag_q <= 1'b1;
         end else if (flag_clr) begin
            flag_q <= 1'b0;
         end
         if (take) begin
            gie_q <= 1'b0;
            insvc_q <= 1'b1;
            saved_q <= {core_ctx.pc, core_ctx.page, core_ctx.memory_address_high, cz_q};
         end else if (return_from_interrupt_instr_go) begin
            gie_q <= 1'b1;
            insvc_q <= 1'b0;
         end else if (wr_fire & hit_ctrl) begin
            gie_q <= wnib[ihw_pkg::CTRL_GIE_BIT];
         end
      end
   end

   // carry/zero: restore on return first, then core, then software
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cz_q <= 2'b00;
      end else if (return_from_interrupt_instr_go) begin
         cz_q <= saved_q.cz;
      end else if (core_cz_we) begin
         cz_q <= core_cz;
      end else if (wr_fire & hit_status) begin
         cz_q <= wnib[1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         aud_en_q <= ihw_pkg::RST_AUD_EN;
         lowest_q <= ihw_pkg::RST_NIBBLE;
         low_q <= ihw_pkg::RST_NIBBLE;
         high_q <= ihw_pkg::RST_NIBBLE;
      end else begin
         if (halt_go | wdt_ovf) begin
            aud_en_q <= 1'b0;
         end else if (wr_fire & hit_ctrl) begin
            aud_en_q <= wnib[ihw_pkg::CTRL_EN_BIT];
         end
         if (wr_fire & hit_lowest) begin
            lowest_q <= wnib;
         end
         if (wr_fire & hit_low) begin
            low_q <= wnib;
         end
         if (wr_fire & hit_high) begin
            high_q <= wnib;
         end
      end
   end

   // output cycle; sample swaps only at cycle end so a mid-cycle write is safe
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_q <= '0;
         act_sign_q <= 1'b0;
         act_mag_q <= '0;
      end else begin
         cyc_q <= (cyc_end | ~run) ? '0 : cyc_q + AUD_W'(1);
         if (cyc_end) begin
            act_sign_q <= high_q[ihw_pkg::SIGN_BIT];
            act_mag_q <= mag_sel;
         end
      end
   end

   // pins; 12 bit codes above the cycle length saturate at full duty
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         out_p_q <= 1'b0;
         out_n_q <= 1'b0;
         out_oe_q <= 1'b1;
      end else begin
         out_p_q <= aud_en_q & run & ~act_sign_q & pulse_on;
         out_n_q <= aud_en_q & run & act_sign_q & pulse_on;
         out_oe_q <= (st_d != ihw_pkg::ST_HALT);
      end
   end

   // core side; sram sits in the core and sees no write here while halted
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_load_q <= 1'b0;
         pc_addr_q <= ihw_pkg::VEC_RESET;
         ctx_restore_q <= 1'b0;
         restore_ctx_q <= '0;
         core_run_q <= 1'b0;
         halted_q <= 1'b0;
      end else begin
         pc_load_q <= take | halt_go | wdt_ovf | return_from_interrupt_instr_go;
         if (wdt_ovf) begin
            pc_addr_q <= ihw_pkg::VEC_RESET;
         end else if (halt_go) begin
            pc_addr_q <= ihw_pkg::VEC_WAKE;
         end else if (take) begin
            pc_addr_q <= ihw_pkg::VEC_INT;
         end else if (return_from_interrupt_instr_go) begin
            pc_addr_q <= saved_q.pc;
         end
         ctx_restore_q <= return_from_interrupt_instr_go;
         if (return_from_interrupt_instr_go) begin
            restore_ctx_q <= saved_q;
         end
         core_run_q <= (st_d == ihw_pkg::ST_RUN);
         halted_q <= (st_d == ihw_pkg::ST_HALT);
      end
   end

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign pc_load = pc_load_q;
   assign pc_load_addr = pc_addr_q;
   assign ctx_restore = ctx_restore_q;
   assign restore_ctx = restore_ctx_q;
   assign carry_zero = cz_q;
   assign core_run = core_run_q;
   assign halted = halted_q;
   assign wdt_chip_reset = wdt_rst_q;
   assign audio_out_positive = out_p_q;
   assign audio_out_negative = out_n_q;
   assign audio_out_oe = out_oe_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   take_vector_a: assert property (
      take && !wdt_ovf |=> pc_load_q && pc_addr_q == ihw_pkg::VEC_INT && !gie_q && insvc_q)
      else $error("interrupt take did not load vector and clear enable");
   take_save_a: assert property (
      take && !wdt_ovf |=> saved_q.pc == $past(core_ctx.pc) && saved_q.cz == $past(cz_q))
      else $error("context not saved on interrupt take");
   pending_take_a: assert property (
      run && gie_q && flag_q && !insvc_q && !instr_halt && !wdt_ovf |=> pc_load_q)
      else $error("pending request not taken on next clock");
   flag_kept_a: assert property (
      take && !flag_clr && !wdt_ovf |=> flag_q)
      else $error("hardware cleared the audio flag on take");
   no_nest_a: assert property (
      insvc_q && !return_from_interrupt_instr_go && !halt_go && !wdt_ovf |=> insvc_q && !pc_load_q)
      else $error("nested interrupt accepted");
   return_from_interrupt_instr_restore_a: assert property (
      return_from_interrupt_instr_go && !wdt_ovf |=> gie_q && ctx_restore_q && pc_addr_q == $past(saved_q.pc))
      else $error("return did not restore context and enable");
   halt_entry_a: assert property (
      halt_go && !wdt_ovf |=> pc_addr_q == ihw_pkg::VEC_WAKE && halted_q && !aud_en_q
      && !audio_out_oe && wdt_q == '0)
      else $error("halt entry wrong");
   halt_float_a: assert property (
      halted_q |-> !out_oe_q)
      else $error("audio pins driven while halted");
   wake_start_a: assert property (
      wake_go |=> st_q == ihw_pkg::ST_WAKE && !core_run_q ##1 !core_run_q)
      else $error("wakeup edge ignored or run too early");
   delay_hold_a: assert property (
      (st_q == ihw_pkg::ST_WAKE || st_q == ihw_pkg::ST_RESET) && !dly_done |=> !core_run_q)
      else $error("core released before restart delay");
   wdt_clear_a: assert property (
      rom_wr |=> wdt_q == '0)
      else $error("rom high nibble write did not clear watchdog");
   wdt_reset_a: assert property (
      wdt_ovf |=> wdt_rst_q && st_q == ihw_pkg::ST_RESET && pc_addr_q == ihw_pkg::VEC_RESET)
      else $error("watchdog overflow did not reset");
   cycle_flag_a: assert property (
      cyc_end && !wdt_ovf |=> flag_q && act_mag_q == $past(mag_sel))
      else $error("cycle end did not raise flag and load sample");
   disabled_low_a: assert property (
      !aud_en_q |=> !out_p_q && !out_n_q)
      else $error("audio pins active while disabled");

   take_c: cover property (take ##[1:200] return_from_interrupt_instr_go);
   halt_wake_c: cover property (halt_go ##[1:50] wake_go);
   wdt_c: cover property (wdt_ovf);
   pulse_c: cover property (out_p_q ##1 !out_p_q);
endmodule
`default_nettype wire

// ==== test/ihw_core_model.sv ====
// stand-in for the processor core: program counter and its context lines
`timescale 1ns/1ps
`default_nettype none
module ihw_core_model (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic pc_load,
   input wire logic [11:0] pc_load_addr,
   input wire logic ctx_restore,
   input wire ihw_pkg::ihw_ctx_t restore_ctx,
   input wire logic core_run,
   output wire ihw_pkg::ihw_core_t core_ctx
);
   logic [11:0] pc_q;
   logic [7:0] ctx_q;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_q <= 12'h000;
         ctx_q <= 8'h00;
      end else if (ctx_restore) begin
         pc_q <= restore_ctx.pc;
         ctx_q <= {restore_ctx.page, restore_ctx.memory_address_high};
      end else if (pc_load) begin
         pc_q <= pc_load_addr;
      end else if (core_run) begin
         // page and address-high drift so a stale save shows up
         pc_q <= pc_q + 12'h001;
         ctx_q <= ctx_q + 8'h13;
      end
   end
   assign core_ctx = {pc_q, ctx_q};
endmodule
`default_nettype wire

// ==== test/tb_ihw_sysctl.sv ====
// self-checking bench of the system-control block
`timescale 1ns/1ps
`default_nettype none
module tb_ihw_sysctl;
   localparam int RD = 20;
   localparam int WD = 50;
   localparam int AP = 16;
   // {ten, twelve, lowest, low, high, pin, width}
   localparam logic [22:0] AT [5] = '{{2'h0, 12'hf50, 1'b0, 8'h05}, {2'h0, 12'h038, 1'b1, 8'h03},
      {2'h2, 12'hc10, 1'b0, 8'h07}, {2'h2, 12'h320, 1'b0, 8'h08}, {2'h3, 12'h908, 1'b1, 8'h09}};
   logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic core_cz_we = 1'b0, instr_return_from_interrupt_instr = 1'b0, instr_halt = 1'b0, wdt_en = 1'b0;
   logic ten = 1'b0, twelve = 1'b0, no_int = 1'b1;
   logic [1:0] core_cz = 2'h0, wake_pin = 2'h0, cur_cz, carry_zero, prev_cz;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, pc_load, ctx_restore, core_run, halted, wdt_rst, a_pos, a_neg, a_oe;
   logic [11:0] pc_load_addr;
   logic [7:0] wcnt [2] = '{8'h00, 8'h00};
   ihw_pkg::ihw_core_t core_ctx, prev_ctx;
   ihw_pkg::ihw_ctx_t restore_ctx, saved, s1;
   logic [32:0] rd_q [$];
   logic [11:0] pc_q [$];
   logic [24:0] aud_q [$];
   int bad_count = 0, checks_done = 0, cyc = 0, last_rise = 0, per = 0, wdt_n = 0, n, i;
   integer seed = 32'h1363_35a0;
   wire logic [1:0] apin = {a_neg, a_pos};

   ihw_sysctl #(.RESTART_DELAY_CYC(RD), .WDT_TIMEOUT_CYC(WD), .AUDIO_PERIOD_CYC(AP)) ihw_sysctl_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .core_ctx(core_ctx), .core_cz_we(core_cz_we), .core_cz(core_cz), .instr_return_from_interrupt_instr(instr_return_from_interrupt_instr),
      .instr_halt(instr_halt), .wake_pin(wake_pin), .wake_enable_option(2'h1),
      .wdt_enable_option(wdt_en), .ten_bit_select_option(ten), .twelve_bit_select_option(twelve),
      .pc_load(pc_load), .pc_load_addr(pc_load_addr), .ctx_restore(ctx_restore),
      .restore_ctx(restore_ctx), .carry_zero(carry_zero), .core_run(core_run), .halted(halted),
      .wdt_chip_reset(wdt_rst), .audio_out_positive(a_pos), .audio_out_negative(a_neg),
      .audio_out_oe(a_oe));

   ihw_core_model ihw_core_model_i (.ref_clk(ref_clk), .arst_n(arst_n), .pc_load(pc_load),
      .pc_load_addr(pc_load_addr), .ctx_restore(ctx_restore), .restore_ctx(restore_ctx),
      .core_run(core_run), .core_ctx(core_ctx));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic tend(input string name);
      $display("test %s done", name);
   endtask

   // expectation is queued before the request so the watcher always finds it
   task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] d, input logic [32:0] e);
      int k;
      k = 0;
      rd_q.push_back(e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {28'h000_0000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) bad_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      apb(1'b1, a, d, 33'h0_0000_0000);
   endtask

   task automatic rd(input logic [7:0] a, input logic [3:0] d, input logic err);
      apb(1'b0, a, 4'h0, {err, 28'h000_0000, d});
   endtask

   task automatic wait_run;
      n = 0;
      while (core_run !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   task automatic halt_pulse;
      pc_q.push_back(ihw_pkg::VEC_WAKE);
      instr_halt <= 1'b1;
      @(posedge ref_clk);
      instr_halt <= 1'b0;
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      prev_ctx <= core_ctx;
      prev_cz <= carry_zero;
      if (wdt_rst === 1'b1) wdt_n <= wdt_n + 1;
      if (psel && penable && pready === 1'b1 && rd_q.size() > 0) begin
         check({pslverr, pwrite ? 32'h0000_0000 : prdata}, rd_q.pop_front());
      end
      if (pc_load === 1'b1) begin
         if (pc_load_addr === ihw_pkg::VEC_INT) begin
            saved <= {prev_ctx, prev_cz};
            check(33'(no_int), 33'h0);
         end
         if (pc_q.size() > 0) check(33'(pc_load_addr), 33'(pc_q.pop_front()));
      end
      if (ctx_restore === 1'b1) check(33'(restore_ctx), 33'(saved));
      for (int j = 0; j < 2; j++) begin
         if (apin[j] === 1'b1) begin
            if (wcnt[j] == 8'h00) begin
               per <= cyc - last_rise;
               last_rise <= cyc;
            end
            wcnt[j] <= wcnt[j] + 8'h01;
         end else if (wcnt[j] != 8'h00) begin
            if (aud_q.size() > 0) check(33'({j[0], wcnt[j], per[15:0]}), 33'(aud_q.pop_front()));
            wcnt[j] <= 8'h00;
         end
      end
      if (cyc == 6000) begin
         bad_count++;
         test_done();
      end
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      wait_run();
      rd(8'h24, 4'h0, 1'b0);
      rd(8'h20, 4'h0, 1'b0);
      rd(8'h80, 4'h0, 1'b1);
      rd(8'h22, 4'h0, 1'b1);
      cur_cz = 2'($random(seed));
      wr(8'h00, {2'h0, cur_cz});
      repeat (2) @(posedge ref_clk);
      check(33'(carry_zero), 33'(cur_cz));
      cur_cz = 2'($random(seed));
      core_cz <= cur_cz;
      core_cz_we <= 1'b1;
      @(posedge ref_clk);
      core_cz_we <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(33'(carry_zero), 33'(cur_cz));
      tend("registers");
      // flag comes up while the enable is clear and has to wait
      repeat (2 * AP) @(posedge ref_clk);
      pc_q.push_back(ihw_pkg::VEC_INT);
      no_int <= 1'b0;
      wr(8'h24, 4'h2);
      repeat (6) @(posedge ref_clk);
      no_int <= 1'b1;
      check(33'(pc_q.size()), 33'h0);
      repeat (3 * AP) @(posedge ref_clk);
      rd(8'h24, 4'h0, 1'b0);
      rd(8'h00, {2'h1, cur_cz}, 1'b0);
      s1 = saved;
      core_cz <= ~s1.cz;
      core_cz_we <= 1'b1;
      @(posedge ref_clk);
      core_cz_we <= 1'b0;
      pc_q.push_back(s1.pc);
      pc_q.push_back(ihw_pkg::VEC_INT);
      no_int <= 1'b0;
      instr_return_from_interrupt_instr <= 1'b1;
      @(posedge ref_clk);
      instr_return_from_interrupt_instr <= 1'b0;
      repeat (8) @(posedge ref_clk);
      no_int <= 1'b1;
      check(33'(pc_q.size()), 33'h0);
      check(33'(carry_zero), 33'(s1.cz));
      wr(8'h00, {2'h0, s1.cz});
      tend("interrupt");
      for (i = 0; i < 5; i++) begin
         {ten, twelve} <= AT[i][22:21];
         wr(8'h20, AT[i][20:17]);
         wr(8'h28, AT[i][16:13]);
         wr(8'h2c, AT[i][12:9]);
         wr(8'h24, 4'h1);
         repeat (3 * AP) @(posedge ref_clk);
         aud_q.push_back({AT[i][8:0], 16'(AP)});
         aud_q.push_back({AT[i][8:0], 16'(AP)});
         repeat (3 * AP) @(posedge ref_clk);
      end
      check(33'(aud_q.size()), 33'h0);
      wr(8'h24, 4'h0);
      repeat (AP + 2) @(posedge ref_clk);
      for (i = 0; i < AP; i++) begin
         @(posedge ref_clk);
         check(33'({a_oe, a_pos, a_neg}), 33'h4);
      end
      tend("audio");
      wdt_en <= 1'b1;
      wr(8'h24, 4'h1);
      wr(8'h74, 4'($random(seed)));
      repeat (40) @(posedge ref_clk);
      halt_pulse();
      repeat (2) @(posedge ref_clk);
      check(33'({halted, core_run, a_oe}), 33'h4);
      wake_pin <= 2'h2;
      repeat (10) @(posedge ref_clk);
      check(33'(halted), 33'h1);
      wake_pin <= 2'h3;
      wait_run();
      check(33'(n >= RD && n <= RD + 8), 33'h1);
      rd(8'h24, 4'h0, 1'b0);
      wake_pin <= 2'h0;
      repeat (30) @(posedge ref_clk);
      check(33'(wdt_n), 33'h0);
      wdt_en <= 1'b0;
      tend("halt wake");
      halt_pulse();
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      wait_run();
      check(33'(n >= RD && n <= RD + 4), 33'h1);
      check(33'({halted, pc_load_addr}), 33'(ihw_pkg::VEC_RESET));
      tend("halt reset");
      wdt_en <= 1'b1;
      for (i = 0; i < 6; i++) begin
         repeat (30) @(posedge ref_clk);
         wr(8'h74, 4'($random(seed)));
      end
      check(33'(wdt_n), 33'h0);
      n = 0;
      while (wdt_n == 0 && n < 2 * WD) begin
         @(posedge ref_clk);
         n++;
      end
      check(33'(n >= WD - 3 && n <= WD + 3), 33'h1);
      @(posedge ref_clk);
      check(33'(core_run), 33'h0);
      wait_run();
      check(33'(n >= RD - 2 && n <= RD + 4), 33'h1);
      repeat (40) @(posedge ref_clk);
      check(33'(wdt_n), 33'h1);
      wdt_en <= 1'b0;
      tend("watchdog");
      test_done();
   end
endmodule
`default_nettype wire
